// file: cfg_msg_map.svh
// Constants for the serial-bus configuration message handler.
// Assumes inclusion by bare name from any file that needs them.
`ifndef CFG_MSG_MAP_SVH
`define CFG_MSG_MAP_SVH

// Path select codes in status bits 7:6
`define PATH_GENERAL 2'h0
`define PATH_ONE 2'h1
`define PATH_TWO 2'h2
`define PATH_THREE 2'h3
// Subcodes in status bits 5:0
`define SUB_SETUP 6'h27
`define SUB_REQUEST 6'h07
// Whole status bytes
`define STAT_GEN_REQ 8'h08
`define STAT_GEN_RSP 8'h28
`define STAT_DATA_REQ3 8'hC1
`define STAT_CI_CHANGE 8'h80
// Control high byte fields of the path 3 setup
`define BIT_DCHAN 7
`define BIT_ARB 6
`define BIT_CMDIND 5
`define ARB_ADDR_HI 2
`define ARB_ADDR_LO 0
// Flags in the general response control high byte
`define BIT_DOUBLE_CLK 6
`define BIT_AWAKE 5
// Companding and slot length codes
`define COMP_LINEAR 3'h0
`define COMP_ALAW 3'h1
`define COMP_MULAW 3'h2
`define SLOT_8BIT 3'h0
`define SLOT_16BIT 3'h2
// Pump mode codes
`define PUMP_DIGITAL 3'h4
// AXI4-Lite register offsets on the host side
`define REG_CMD 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0C
`define REG_RESP 8'h10
`define REG_CONFIG 8'h14
// Event bits in the host status register
`define EV_RESP 0
`define EV_DONE 1
`define EV_ERROR 2
`define EV_COUNT 3
// Response kinds
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// file: cfg_msg_pkg.sv
// Types shared by both ends of the configuration message link.
// Assumes cfg_msg_map.svh holds the numeric constants.
package cfg_msg_pkg;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        byte_t status;
        byte_t ctrlHigh;
        byte_t ctrlLow;
    } msg_t;
endpackage

// file: cfg_msg_if.sv
// Message register link between the host and the device handler.
// Assumes both ends share clk; each message is one valid/ready beat.
`timescale 1ns/10ps
interface cfg_msg_if;
    cfg_msg_pkg::msg_t hostMsg;
    logic hostValid;
    logic hostReady;
    cfg_msg_pkg::msg_t devMsg;
    logic devValid;
    logic devReady;
    modport device (input hostMsg, input hostValid, output hostReady,
        output devMsg, output devValid, input devReady);
    modport host (output hostMsg, output hostValid, input hostReady,
        input devMsg, input devValid, output devReady);
endinterface

// file: cfg_msg_device.sv
// Device end: decodes setup and request messages and answers them.
// Assumes the host keeps its own message encoding rules.
`timescale 1ns/10ps
`include "cfg_msg_map.svh"
module cfg_msg_device (
    input wire logic clk,
    input wire logic resetn,
    cfg_msg_if.device link,
    input wire logic [7:0] rxCmdIndicate,
    input wire logic awakeActive,
    output logic dchanEnable,
    output logic arbitrationBusEnable,
    output logic cmdIndicateEnable,
    output logic [2:0] arbitrationBusAddress,
    output logic dchanBufferClear
);
    typedef enum logic [1:0] {IDLE = 2'b00, SEND = 2'b01, NEXT = 2'b11} dev_state_t;
    dev_state_t state;
    cfg_msg_pkg::msg_t pend;
    logic pendCi;
    logic [7:0] ciHold;
    logic isSetup3;
    logic isGenReq;
    logic isPathReq;
    logic take;

    // Message decoding
    assign take = link.hostValid && link.hostReady;
    assign isSetup3 = link.hostMsg.status == {`PATH_THREE, `SUB_SETUP};
    assign isGenReq = link.hostMsg.status == `STAT_GEN_REQ;
    assign isPathReq = (link.hostMsg.status[5:0] == `SUB_REQUEST)
        && (link.hostMsg.status[7:6] != `PATH_GENERAL);
    assign link.hostReady = (state == IDLE);

    // Register C/I code every cycle for the change message
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ciHold <= 8'h00;
        end else begin
            ciHold <= rxCmdIndicate;
        end
    end

    // Path 3 configuration from the setup message
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dchanEnable <= 1'b0;
            arbitrationBusEnable <= 1'b0;
            cmdIndicateEnable <= 1'b0;
            arbitrationBusAddress <= 3'h0;
        end else if (take && isSetup3) begin
            dchanEnable <= link.hostMsg.ctrlHigh[`BIT_DCHAN];
            arbitrationBusEnable <= link.hostMsg.ctrlHigh[`BIT_ARB];
            cmdIndicateEnable <= link.hostMsg.ctrlHigh[`BIT_CMDIND];
            arbitrationBusAddress <= link.hostMsg.ctrlHigh[`ARB_ADDR_HI:`ARB_ADDR_LO];
        end
    end

    // Buffer clear pulse on every path 3 setup
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dchanBufferClear <= 1'b0;
        end else begin
            dchanBufferClear <= take && isSetup3;
        end
    end

    // Answer sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= IDLE;
            pend <= '0;
            pendCi <= 1'b0;
            link.devMsg <= '0;
            link.devValid <= 1'b0;
        end else begin
            unique case (state)
                IDLE: begin
                    if (take && isSetup3 && link.hostMsg.ctrlHigh[`BIT_DCHAN]) begin
                        link.devMsg <= '{`STAT_DATA_REQ3, 8'h00, 8'h00};
                        link.devValid <= 1'b1;
                        pendCi <= link.hostMsg.ctrlHigh[`BIT_CMDIND];
                        pend <= '{`STAT_CI_CHANGE, ciHold, 8'h00};
                        state <= SEND;
                    end else if (take && isSetup3 && link.hostMsg.ctrlHigh[`BIT_CMDIND]) begin
                        link.devMsg <= '{`STAT_CI_CHANGE, ciHold, 8'h00};
                        link.devValid <= 1'b1;
                        pendCi <= 1'b0;
                        state <= SEND;
                    end else if (take && isGenReq) begin
                        link.devMsg <= '{`STAT_GEN_RSP,
                            {1'b0, 1'b1, awakeActive, 5'h00}, 8'h00};
                        link.devValid <= 1'b1;
                        pendCi <= 1'b0;
                        state <= SEND;
                    end else if (take && isPathReq) begin
                        link.devMsg <= '{link.hostMsg.status, 8'h00, 8'h00};
                        link.devValid <= 1'b1;
                        pendCi <= 1'b0;
                        state <= SEND;
                    end
                end
                SEND: begin
                    if (link.devReady) begin
                        link.devValid <= 1'b0;
                        state <= pendCi ? NEXT : IDLE;
                    end
                end
                NEXT: begin
                    link.devMsg <= pend;
                    link.devValid <= 1'b1;
                    pendCi <= 1'b0;
                    state <= SEND;
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule

// file: cfg_msg_host.sv
// Host end: AXI4-Lite registers turned into configuration messages.
// Assumes software writes the command word, then the go bit.
// Notes on behaviour
// - Digital pump mode requires no companding.
// - Modulation modes use A-law or mu-law, 8-bit slots.
// - Linear samples need companding off, 16-bit slots; digital pump mode here also accepts 8-bit slots.
// - Setup with D-channel on yields one data request.
// - Every path 3 setup clears D-channel buffers.
// - Enabling C/I sends current code change message.
// - Host programs outgoing C/I codes before enabling.
// - Requests carry zero control bytes, no mailbox.
// - General and per-path requests get distinct answers.
// - Path select codes 01 to 11 name paths.
// - General request answered by general response.
// - Response clock-ratio flag one: double-rate bit clock.
// - Response awake flag set: upstream line held low.
// - Slot length codes 000 and 010 only.
// - Coding codes 000, 001, 010 only; rest reserved.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "cfg_msg_map.svh"
module cfg_msg_host (
    input wire logic clk,
    input wire logic resetn,
    cfg_msg_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    logic [23:0] cmd;
    logic [2:0] comp;
    logic [2:0] slot;
    logic [2:0] pump;
    logic [2:0] evStatus;
    logic [2:0] evMask;
    logic [23:0] resp;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic doWrite;
    logic doRead;
    logic goHit;
    logic comboBad;
    logic [2:0] evSet;

    // Allowed companding, slot and pump combinations
    function automatic logic combo_ok(input logic [2:0] p, input logic [2:0] c,
        input logic [2:0] s);
        if (p == `PUMP_DIGITAL) begin
            combo_ok = (c == `COMP_LINEAR) && (s == `SLOT_8BIT || s == `SLOT_16BIT);
        end else if (c == `COMP_LINEAR) begin
            combo_ok = (s == `SLOT_16BIT);
        end else begin
            combo_ok = (c <= `COMP_MULAW) && (s == `SLOT_8BIT);
        end
    endfunction

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign goHit = doWrite && awAddr == `REG_CTRL && wData[0] && !link.hostValid;
    assign comboBad = !combo_ok(pump, comp, slot);
    assign evSet = {goHit && comboBad, link.hostValid && link.hostReady,
        link.devValid && link.devReady};

    // Write address and data capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr > `REG_CONFIG) ? `AXI_SLVERR : `AXI_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software registers and message launch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd <= 24'h00_0000;
            comp <= `COMP_LINEAR;
            slot <= `SLOT_8BIT;
            pump <= 3'h0;
            evMask <= 3'h0;
            link.hostMsg <= '0;
            link.hostValid <= 1'b0;
        end else begin
            if (doWrite && awAddr == `REG_CMD && s_axi_wstrb[2:0] == 3'h7) begin
                cmd <= wData[23:0];
            end
            if (doWrite && awAddr == `REG_CONFIG) begin
                {pump, slot, comp} <= wData[8:0];
            end
            if (doWrite && awAddr == `REG_MASK) begin
                evMask <= wData[`EV_COUNT-1:0];
            end
            if (goHit && !comboBad) begin
                link.hostMsg <= cmd;
                if (cmd[23:16] == `STAT_GEN_REQ || cmd[21:16] == `SUB_REQUEST) begin
                    link.hostMsg.ctrlHigh <= 8'h00;
                    link.hostMsg.ctrlLow <= 8'h00;
                end
                link.hostValid <= 1'b1;
            end else if (link.hostReady) begin
                link.hostValid <= 1'b0;
            end
        end
    end

    // Latest device message and sticky events, read of status clears
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp <= 24'h00_0000;
            evStatus <= 3'h0;
            link.devReady <= 1'b0;
        end else begin
            link.devReady <= 1'b1;
            if (link.devValid && link.devReady) begin
                resp <= link.devMsg;
            end
            if (doRead && s_axi_araddr == `REG_STATUS) begin
                evStatus <= evSet;
            end else begin
                evStatus <= evStatus | evSet;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_OKAY;
        end else if (doRead) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            unique case (s_axi_araddr)
                `REG_CMD: s_axi_rdata <= {8'h00, cmd};
                `REG_CTRL: s_axi_rdata <= {31'h0000_0000, link.hostValid};
                `REG_STATUS: s_axi_rdata <= {29'h0000_0000, evStatus};
                `REG_MASK: s_axi_rdata <= {29'h0000_0000, evMask};
                `REG_RESP: s_axi_rdata <= {8'h00, resp};
                `REG_CONFIG: s_axi_rdata <= {23'h00_0000, pump, slot, comp};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evStatus & evMask);
        end
    end
endmodule

// file: cfg_msg_props.sv
// Checker for the message link between the host and device ends.
// Assumes the bench instantiates it beside the interface instance.
`timescale 1ns/10ps
`include "cfg_msg_map.svh"
module cfg_msg_props (
    input wire logic clk,
    input wire logic resetn,
    input wire cfg_msg_pkg::msg_t hostMsg,
    input wire logic hostValid,
    input wire logic hostReady,
    input wire cfg_msg_pkg::msg_t devMsg,
    input wire logic devValid,
    input wire logic devReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic take;
    logic setup;
    // Message taken, and taken message is a path 3 setup
    assign take = hostValid && hostReady;
    assign setup = take && hostMsg.status == {`PATH_THREE, `SUB_SETUP};
    property p_genAnswer;
        take && hostMsg.status == `STAT_GEN_REQ |=> devValid && devMsg.status == `STAT_GEN_RSP;
    endproperty
    a_genAnswer: assert property (p_genAnswer) else $error("general answer missing");
    property p_dblClk;
        devValid && devMsg.status == `STAT_GEN_RSP |->
            devMsg.ctrlHigh[`BIT_DOUBLE_CLK] && devMsg.ctrlLow == 8'h00;
    endproperty
    a_dblClk: assert property (p_dblClk) else $error("clock ratio flag wrong");
    property p_dataReq;
        setup && hostMsg.ctrlHigh[`BIT_DCHAN] |=> devValid && devMsg.status == `STAT_DATA_REQ3;
    endproperty
    a_dataReq: assert property (p_dataReq) else $error("data request missing");
    property p_oneReq;
        devValid && devReady && devMsg.status == `STAT_DATA_REQ3 |=>
            !(devValid && devMsg.status == `STAT_DATA_REQ3) [*4];
    endproperty
    a_oneReq: assert property (p_oneReq) else $error("second data request");
    property p_ciChange;
        setup && !hostMsg.ctrlHigh[`BIT_DCHAN] && hostMsg.ctrlHigh[`BIT_CMDIND] |=>
            devValid && devMsg.status == `STAT_CI_CHANGE;
    endproperty
    a_ciChange: assert property (p_ciChange) else $error("code change missing");
    property p_silent;
        setup && !hostMsg.ctrlHigh[`BIT_DCHAN] && !hostMsg.ctrlHigh[`BIT_CMDIND] |=> !devValid [*3];
    endproperty
    a_silent: assert property (p_silent) else $error("unexpected answer");
    property p_pathEcho;
        take && hostMsg.status[5:0] == `SUB_REQUEST && hostMsg.status[7:6] != 2'h0 |=>
            devValid && devMsg.status == $past(hostMsg.status) && devMsg.ctrlHigh == 8'h00;
    endproperty
    a_pathEcho: assert property (p_pathEcho) else $error("path answer wrong");
    property p_reqZero;
        hostValid && (hostMsg.status == `STAT_GEN_REQ || hostMsg.status[5:0] == `SUB_REQUEST)
            |-> hostMsg.ctrlHigh == 8'h00 && hostMsg.ctrlLow == 8'h00;
    endproperty
    a_reqZero: assert property (p_reqZero) else $error("request control not zero");
    // Main scenarios reached
    c_gen: cover property (take && hostMsg.status == `STAT_GEN_REQ);
    c_setup: cover property (setup && hostMsg.ctrlHigh[`BIT_DCHAN]);
    c_ci: cover property (devValid && devMsg.status == `STAT_CI_CHANGE);
endmodule

// file: serial_bus_config_messages_bench.sv
// Bench joining host and device ends, driving AXI4-Lite and device inputs.
// Assumes the device answers on the link and the host posts on go.
`timescale 1ns/10ps
`include "cfg_msg_map.svh"
module serial_bus_config_messages_bench;
    logic clk = 0;
    logic resetn = 0;
    logic [7:0] awaddr = 0, araddr = 0, rxCi = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awake = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, dEn, arbEn, ciEn, clr;
    logic [1:0] bresp, rresp;
    logic [2:0] arbAddr;
    cfg_msg_pkg::msg_t devQ[$];
    cfg_msg_pkg::msg_t hostLast;
    int err_total = 0, checks_done = 0, clrCnt = 0, hostCnt = 0, cycles = 0;
    cfg_msg_if link ();
    // Free-running clock
    always #10 clk = ~clk;
    cfg_msg_host cfg_msg_host_i (.clk(clk), .resetn(resetn), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    cfg_msg_device cfg_msg_device_i (.clk(clk), .resetn(resetn), .link(link),
        .rxCmdIndicate(rxCi), .awakeActive(awake), .dchanEnable(dEn),
        .arbitrationBusEnable(arbEn), .cmdIndicateEnable(ciEn),
        .arbitrationBusAddress(arbAddr), .dchanBufferClear(clr));
    cfg_msg_props cfg_msg_props_i (.clk(clk), .resetn(resetn), .hostMsg(link.hostMsg),
        .hostValid(link.hostValid), .hostReady(link.hostReady), .devMsg(link.devMsg),
        .devValid(link.devValid), .devReady(link.devReady));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Link monitor, clear pulse counter and hang limit
    always @(posedge clk) begin
        cycles++;
        if (link.devValid && link.devReady) devQ.push_back(link.devMsg);
        if (link.hostValid && link.hostReady) begin
            hostCnt++;
            hostLast = link.hostMsg;
        end
        if (clr) clrCnt++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        bit aw = 0, w = 0, b = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 0;
            end
            if (bvalid) begin
                b = 1;
                bready <= 0;
                chk(bresp, er);
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        bit ar = 0, r = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!r) begin
            @(posedge clk);
            if (!ar && arready) begin
                ar = 1;
                arvalid <= 0;
            end
            if (rvalid) begin
                r = 1;
                v = rdata;
                rready <= 0;
                chk(rresp, er);
            end
        end
    endtask
    task automatic send(input logic [23:0] m);
        wr(`REG_CMD, {8'h00, m}, `AXI_OKAY);
        devQ.delete();
        wr(`REG_CTRL, 32'h0000_0001, `AXI_OKAY);
        repeat (12) @(posedge clk);
    endtask
    task automatic tRegs();
        rd(`REG_STATUS, d, `AXI_OKAY);
        chk(d, 32'h0000_0000);
        rd(`REG_MASK, d, `AXI_OKAY);
        chk(d, 32'h0000_0000);
        rd(8'h18, d, `AXI_SLVERR);
        chk(d, 32'h0000_0000);
        wr(8'h20, 32'h1234_5678, `AXI_SLVERR);
    endtask
    task automatic tSetups();
        logic [7:0] tbl [5] = '{8'hC5, 8'hC5, 8'hA5, 8'h22, 8'h00};
        int c;
        foreach (tbl[i]) begin
            c = clrCnt;
            rxCi <= {4'h3, i[3:0]};
            send({8'hE7, tbl[i], 8'h00});
            chk(clrCnt - c, 1);
            chk(devQ.size(), int'(tbl[i][7]) + int'(tbl[i][5]));
            if (tbl[i][7]) chk(devQ[0].status, `STAT_DATA_REQ3);
            if (tbl[i][5]) chk(devQ[devQ.size() - 1], {`STAT_CI_CHANGE, 4'h3, i[3:0], 8'h00});
            chk({dEn, arbEn, ciEn, arbAddr}, {tbl[i][7:5], tbl[i][2:0]});
        end
    endtask
    task automatic tRequests();
        for (int k = 0; k < 2; k++) begin
            awake <= k[0];
            send({`STAT_GEN_REQ, 16'hFFFF});
            chk(hostLast, {`STAT_GEN_REQ, 16'h0000});
            chk(devQ.size(), 1);
            chk(devQ[0], {`STAT_GEN_RSP, 2'b01, k[0], 5'h00, 8'h00});
            rd(`REG_RESP, d, `AXI_OKAY);
            chk(d, {8'h00, `STAT_GEN_RSP, 2'b01, k[0], 5'h00, 8'h00});
        end
        for (int p = 1; p < 4; p++) begin
            send({p[1:0], `SUB_REQUEST, 16'h0000});
            chk(devQ[0], {p[1:0], `SUB_REQUEST, 16'h0000});
        end
    endtask
    task automatic tCombos();
        logic [9:0] cmb [9] = '{10'h301, 10'h041, 10'h142, 10'h383, 10'h2D9, 10'h251,
            10'h318, 10'h100, 10'h090};
        int n;
        foreach (cmb[i]) begin
            wr(`REG_CONFIG, {23'h0, cmb[i][8:0]}, `AXI_OKAY);
            rd(`REG_CONFIG, d, `AXI_OKAY);
            chk(d, {23'h0, cmb[i][8:0]});
            n = hostCnt;
            send({`STAT_GEN_REQ, 16'h0000});
            chk(hostCnt - n, int'(!cmb[i][9]));
            rd(`REG_STATUS, d, `AXI_OKAY);
            chk(d[`EV_ERROR], cmb[i][9]);
        end
    endtask
    task automatic tIrq();
        wr(`REG_MASK, 32'h0000_0000, `AXI_OKAY);
        send({`STAT_GEN_REQ, 16'h0000});
        chk(irq, 0);
        wr(`REG_MASK, 32'h0000_0002, `AXI_OKAY);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        rd(`REG_STATUS, d, `AXI_OKAY);
        chk(d[2:0], 3'b011);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        rd(`REG_STATUS, d, `AXI_OKAY);
        chk(d, 32'h0000_0000);
    endtask
    // Main sequence after a five-cycle reset
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1;
        tRegs();
        wr(`REG_CONFIG, 32'h0000_0100, `AXI_OKAY);
        tSetups();
        tRequests();
        tCombos();
        tIrq();
        give_verdict();
    end
endmodule
